// *** common/debug_scan_defs.svh ***
// Constants of the debug and boundary-scan port
`ifndef DEBUG_SCAN_DEFS_SVH
`define DEBUG_SCAN_DEFS_SVH
`define IR_W 4
`define IR_EXTEST 4'h0
`define IR_SAMPLE 4'h1
`define IR_SCAN_N 4'h2
`define IR_STM_INSERT 4'h3
`define IR_DCC 4'h5
`define IR_INTEST 4'hC
`define IR_IDCODE 4'hE
`define IR_BYPASS 4'hF
`define IR_CAPTURE 4'h1
`define SEL_W 4
`define NUM_CHAINS 3
`define DCC_W 32
`define BSR_GROUPS_FULL 32
`define BSR_GROUPS_REDUCED 21
`define CELL_CTRL 0
`define CELL_OUT 1
`define CELL_IN 2
`define ID_VER_LSB 28
`define ID_PART_LSB 12
`define ID_MFR_LSB 1
`define SYNC_W 6
`endif

// *** common/debug_scan_pkg.sv ***
// Types of the debug and boundary-scan port
package debug_scan_pkg;
  typedef enum logic [15:0] {
    TAP_RESET = 16'h0001,
    TAP_IDLE = 16'h0002,
    TAP_SEL_DR = 16'h0004,
    TAP_CAP_DR = 16'h0008,
    TAP_SHIFT_DR = 16'h0010,
    TAP_EXIT1_DR = 16'h0020,
    TAP_PAUSE_DR = 16'h0040,
    TAP_EXIT2_DR = 16'h0080,
    TAP_UPD_DR = 16'h0100,
    TAP_SEL_IR = 16'h0200,
    TAP_CAP_IR = 16'h0400,
    TAP_SHIFT_IR = 16'h0800,
    TAP_EXIT1_IR = 16'h1000,
    TAP_PAUSE_IR = 16'h2000,
    TAP_EXIT2_IR = 16'h4000,
    TAP_UPD_IR = 16'h8000
  } tap_state_t;
  typedef enum logic {
    MODE_ICE = 1'b0,
    MODE_BSCAN = 1'b1
  } scan_mode_t;
endpackage

// *** common/tap_if.sv ***
// Link between the port logic and its test access state machine
interface tap_if;
  import debug_scan_pkg::*;
  logic tck_rise;
  logic tms;
  tap_state_t state;
  modport fsm (input tck_rise, input tms, output state);
  modport user (output tck_rise, output tms, input state);
endinterface

// *** rtl/tap_fsm.sv ***
// Test access port state machine stepped on sampled test clock edges
module tap_fsm
  import debug_scan_pkg::*;
(
  input wire logic sys_clk_in, // System clock
  input wire logic srst_in,    // Synchronous reset, active high
  tap_if.fsm tap_port          // Edge strobe, mode select, state
);
  tap_state_t state_q;
  tap_state_t state_d;

  always_comb begin
    state_d = state_q;
    unique case (state_q)
      TAP_RESET: state_d = tap_port.tms ? TAP_RESET : TAP_IDLE;
      TAP_IDLE: state_d = tap_port.tms ? TAP_SEL_DR : TAP_IDLE;
      TAP_SEL_DR: state_d = tap_port.tms ? TAP_SEL_IR : TAP_CAP_DR;
      TAP_CAP_DR: state_d = tap_port.tms ? TAP_EXIT1_DR : TAP_SHIFT_DR;
      TAP_SHIFT_DR: state_d = tap_port.tms ? TAP_EXIT1_DR : TAP_SHIFT_DR;
      TAP_EXIT1_DR: state_d = tap_port.tms ? TAP_UPD_DR : TAP_PAUSE_DR;
      TAP_PAUSE_DR: state_d = tap_port.tms ? TAP_EXIT2_DR : TAP_PAUSE_DR;
      TAP_EXIT2_DR: state_d = tap_port.tms ? TAP_UPD_DR : TAP_SHIFT_DR;
      TAP_UPD_DR: state_d = tap_port.tms ? TAP_SEL_DR : TAP_IDLE;
      TAP_SEL_IR: state_d = tap_port.tms ? TAP_RESET : TAP_CAP_IR;
      TAP_CAP_IR: state_d = tap_port.tms ? TAP_EXIT1_IR : TAP_SHIFT_IR;
      TAP_SHIFT_IR: state_d = tap_port.tms ? TAP_EXIT1_IR : TAP_SHIFT_IR;
      TAP_EXIT1_IR: state_d = tap_port.tms ? TAP_UPD_IR : TAP_PAUSE_IR;
      TAP_PAUSE_IR: state_d = tap_port.tms ? TAP_EXIT2_IR : TAP_PAUSE_IR;
      TAP_EXIT2_IR: state_d = tap_port.tms ? TAP_UPD_IR : TAP_SHIFT_IR;
      TAP_UPD_IR: state_d = tap_port.tms ? TAP_SEL_DR : TAP_IDLE;
      default: state_d = TAP_RESET;
    endcase
  end

  always_ff @(posedge sys_clk_in) begin
    if (srst_in) begin
      state_q <= TAP_RESET;
    end else if (tap_port.tck_rise) begin
      state_q <= state_d;
    end
  end

  assign tap_port.state = state_q;
endmodule // tap_fsm

// *** rtl/debug_scan_port.sv ***
// Debug and boundary-scan port: emulation chains, pin scan, debug unit
// Behaviour
// - Select low routes port to emulation
// - Select high enables boundary scan
// - Select change takes effect after reset
// - Boundary mode offers SAMPLE, EXTEST, BYPASS
// - Emulation identity is processor's own
// - Three processor chains selected and shifted
// - Halted: insert store-multiple, shift registers out
// - Monitor mode exchanges words while running
// - Pin scan register sized as documented
// - Each port pin has three cells
// - Cells drive, capture and set direction
// - Capture high, drive middle, direction low
// - Reduced package drops absent pin groups
// - Channel flags become interrupt sources
// - Blocking stops debugger reaching system
// - Read-only chip identification per variant
// - Serial port paired with two transfer channels
// - Identity: version, part, maker, bit0 one
`include "debug_scan_defs.svh"
module debug_scan_port
  import debug_scan_pkg::*;
#(
  parameter bit REDUCED_PKG = 1'b0,
  parameter logic [3:0] ID_VERSION = 4'h0,
  parameter logic [15:0] ID_PART = 16'h1234,   // Arbitrary value
  parameter logic [10:0] ID_MAKER = 11'h2AA,   // Arbitrary value
  parameter logic [31:0] PROC_ID = 32'h0A5A5A50, // Arbitrary value
  parameter logic [31:0] CHIP_ID = 32'h12345670  // Arbitrary value
) (
  input wire logic sys_clk_in, // 50 MHz system clock
  input wire logic srst_in, // Chip reset, sync, high
  input wire logic scan_port_select_in, // Pin: high = boundary scan
  input wire logic tck_in, // Pin: test clock
  input wire logic tms_in, // Pin: test mode select
  input wire logic tdi_in, // Pin: test data in
  output logic tdo_out, // Pin: test data out
  output logic tdo_oe_out, // Pin: tdo drive enable
  input wire logic erase_in, // Pin: erase, input only
  input wire logic [31:0] pad_in, // Pads: level seen
  output logic [31:0] pad_out, // Pads: level driven
  output logic [31:0] pad_oe_out, // Pads: drive enable
  input wire logic [31:0] core_out_in, // Port logic output value
  input wire logic [31:0] core_oe_in, // Port logic drive enable
  input wire logic cpu_halted_in, // Processor in halt mode
  input wire logic ice_block_in, // Block emulation access
  output logic [1:0] chain_sel_out, // Selected processor chain
  output logic chain_capture_out, // Chain capture pulse
  output logic chain_shift_out, // Chain shift pulse
  output logic chain_update_out, // Chain update pulse
  output logic chain_tdi_out, // Bit into chain
  input wire logic [2:0] chain_tdo_in, // Bit out of each chain
  output logic store_multiple_insert_out, // Pipeline insert pulse
  input wire logic cpu_dcc_wr_in, // Monitor writes a word
  input wire logic [31:0] cpu_dcc_wdata_in, // Word from monitor
  input wire logic cpu_dcc_rd_in, // Monitor took its word
  output logic [31:0] cpu_dcc_rdata_out, // Word for monitor
  output logic comm_channel_tx_flag_out, // Word waits for debugger
  output logic comm_channel_rx_flag_out, // Word waits for monitor
  input wire logic dcc_tx_irq_en_in, // Enable free-slot source
  input wire logic dcc_rx_irq_en_in, // Enable word-ready source
  output logic dcc_irq_out, // Channel interrupt source
  output logic [31:0] chip_id_out, // Chip identification
  input wire logic debug_serial_rx_in, // Pin: serial receive
  output logic debug_serial_tx_out, // Pin: serial transmit
  input wire logic uart_txd_in, // Serial unit transmit bit
  output logic uart_rxd_out, // Serial unit receive bit
  input wire logic uart_rx_ready_in, // Serial unit holds a byte
  input wire logic uart_tx_empty_in, // Serial unit can take one
  output logic pdc_rx_req_out, // Receive channel request
  output logic pdc_tx_req_out // Transmit channel request
);
  // ==========================================================
  // Geometry of the pin scan register
  localparam int GROUPS = REDUCED_PKG ? `BSR_GROUPS_REDUCED : `BSR_GROUPS_FULL;
  localparam int BSR_LEN = 3 * GROUPS + 1;

  // Port pin served by cell group g, group 0 nearest tdo
  function automatic int group_pin(input int g);
    int full_map [32];
    int red_map [21];
    full_map = '{31, 30, 29, 0, 1, 2, 3, 28, 27, 26, 25, 4, 5, 6, 7, 8,
                 9, 10, 11, 12, 24, 23, 22, 13, 14, 15, 16, 20, 19, 21, 18, 17};
    red_map = '{0, 1, 2, 3, 4, 5, 6, 7, 8, 9, 10, 11, 12, 13, 14, 15, 16,
                20, 19, 18, 17};
    return REDUCED_PKG ? red_map[g] : full_map[g];
  endfunction

  if (`NUM_CHAINS > 4 || BSR_LEN < 4) begin : g_check
    $error("debug_scan_port: unsupported geometry");
  end

  // ==========================================================
  // Pin synchronisers
  logic [`SYNC_W-1:0] sync_m_q;
  logic [`SYNC_W-1:0] sync_s_q;
  logic [31:0] pad_m_q;
  logic [31:0] pad_s_q;
  logic tck_d_q;
  logic tck_s;
  logic tms_s;
  logic tdi_s;
  logic sel_s;
  logic erase_s;
  logic rx_s;

  always_ff @(posedge sys_clk_in) begin
    sync_m_q <= {tck_in, tms_in, tdi_in, scan_port_select_in, erase_in,
                 debug_serial_rx_in};
    sync_s_q <= sync_m_q;
    pad_m_q <= pad_in;
    pad_s_q <= pad_m_q;
    tck_d_q <= tck_s;
  end

  assign {tck_s, tms_s, tdi_s, sel_s, erase_s, rx_s} = sync_s_q;

  // ==========================================================
  // Mode, taken only while the chip is in reset
  scan_mode_t mode_q;

  always_ff @(posedge sys_clk_in) begin
    if (srst_in) begin
      mode_q <= scan_mode_t'(sel_s);
    end
  end

  // ==========================================================
  // State machine
  tap_if tap ();
  logic tck_fall;

  assign tap.tck_rise = tck_s & ~tck_d_q;
  assign tap.tms = tms_s;
  assign tck_fall = ~tck_s & tck_d_q;

  tap_fsm u_tap_fsm (
    .sys_clk_in (sys_clk_in),
    .srst_in (srst_in),
    .tap_port (tap)
  );

  logic step;
  tap_state_t st;
  assign step = tap.tck_rise;
  assign st = tap.state;

  // ==========================================================
  // Instruction register
  logic [`IR_W-1:0] ir_sh_q;
  logic [`IR_W-1:0] ir_q;

  always_ff @(posedge sys_clk_in) begin
    if (srst_in) begin
      ir_sh_q <= `IR_CAPTURE;
      ir_q <= `IR_IDCODE;
    end else if (step) begin
      unique case (st)
        TAP_RESET: ir_q <= `IR_IDCODE;
        TAP_CAP_IR: ir_sh_q <= `IR_CAPTURE;
        TAP_SHIFT_IR: ir_sh_q <= {tdi_s, ir_sh_q[`IR_W-1:1]};
        TAP_UPD_IR: ir_q <= ir_sh_q;
        default: ir_q <= ir_q;
      endcase
    end
  end

  // Codes not served by the current mode fall back to bypass
  logic bs_mode;
  logic ice_open;
  logic is_extest;
  logic is_sample;
  logic is_idcode;
  logic is_scan_n;
  logic is_intest;
  logic is_dcc;

  assign bs_mode = (mode_q == MODE_BSCAN);
  assign ice_open = ~bs_mode & ~ice_block_in;
  assign is_extest = bs_mode & (ir_q == `IR_EXTEST);
  assign is_sample = bs_mode & (ir_q == `IR_SAMPLE);
  assign is_idcode = (ir_q == `IR_IDCODE);
  assign is_scan_n = ~bs_mode & (ir_q == `IR_SCAN_N);
  assign is_intest = ice_open & (ir_q == `IR_INTEST);
  assign is_dcc = ice_open & (ir_q == `IR_DCC);

  // ==========================================================
  // Identification
  logic [31:0] id_sh_q;
  logic [31:0] id_word;

  assign id_word = bs_mode ?
      {ID_VERSION, ID_PART, ID_MAKER, 1'b1} : PROC_ID;

  always_ff @(posedge sys_clk_in) begin
    if (srst_in) begin
      id_sh_q <= '0;
    end else if (step && is_idcode) begin
      if (st == TAP_CAP_DR) begin
        id_sh_q <= id_word;
      end else if (st == TAP_SHIFT_DR) begin
        id_sh_q <= {tdi_s, id_sh_q[31:1]};
      end
    end
  end

  // ==========================================================
  // Bypass cell
  logic bypass_q;

  always_ff @(posedge sys_clk_in) begin
    if (srst_in) begin
      bypass_q <= 1'b0;
    end else if (step && st == TAP_CAP_DR) begin
      bypass_q <= 1'b0;
    end else if (step && st == TAP_SHIFT_DR) begin
      bypass_q <= tdi_s;
    end
  end

  // ==========================================================
  // Pin scan register
  logic [BSR_LEN-1:0] bsr_sh_q;
  logic [BSR_LEN-1:0] bsr_upd_q;
  logic [BSR_LEN-1:0] bsr_cap;

  assign bsr_cap[0] = erase_s;

  for (genvar g = 0; g < GROUPS; g++) begin : g_cell
    localparam int P = group_pin(g);
    localparam int B = 3 * g + 1;
    assign bsr_cap[B+`CELL_IN] = pad_s_q[P];
    assign bsr_cap[B+`CELL_OUT] = core_out_in[P];
    assign bsr_cap[B+`CELL_CTRL] = core_oe_in[P];
  end

  always_ff @(posedge sys_clk_in) begin
    if (srst_in) begin
      bsr_sh_q <= '0;
      bsr_upd_q <= '0;
    end else if (step && (is_extest || is_sample)) begin
      unique case (st)
        TAP_CAP_DR: bsr_sh_q <= bsr_cap;
        TAP_SHIFT_DR: bsr_sh_q <= {tdi_s, bsr_sh_q[BSR_LEN-1:1]};
        TAP_UPD_DR: bsr_upd_q <= bsr_sh_q;
        default: bsr_upd_q <= bsr_upd_q;
      endcase
    end
  end

  // Pads pass port logic through unless a test owns them
  always_comb begin
    pad_out = core_out_in;
    pad_oe_out = core_oe_in;
    if (is_extest) begin
      for (int g = 0; g < GROUPS; g++) begin
        pad_out[group_pin(g)] = bsr_upd_q[3*g+1+`CELL_OUT];
        pad_oe_out[group_pin(g)] = bsr_upd_q[3*g+1+`CELL_CTRL];
      end
    end
  end

  // ==========================================================
  // Processor chains
  logic [`SEL_W-1:0] sel_sh_q;
  logic [`SEL_W-1:0] sel_q;
  logic sel_ok;

  assign sel_ok = (sel_q < `NUM_CHAINS);

  always_ff @(posedge sys_clk_in) begin
    if (srst_in) begin
      sel_sh_q <= '0;
      sel_q <= '0;
    end else if (step && is_scan_n) begin
      unique case (st)
        TAP_CAP_DR: sel_sh_q <= sel_q;
        TAP_SHIFT_DR: sel_sh_q <= {tdi_s, sel_sh_q[`SEL_W-1:1]};
        TAP_UPD_DR: sel_q <= sel_sh_q;
        default: sel_q <= sel_q;
      endcase
    end
  end

  // Strobes stay silent while access is blocked
  always_ff @(posedge sys_clk_in) begin
    if (srst_in) begin
      chain_capture_out <= 1'b0;
      chain_shift_out <= 1'b0;
      chain_update_out <= 1'b0;
      chain_tdi_out <= 1'b0;
      chain_sel_out <= '0;
    end else begin
      chain_capture_out <= step & is_intest & sel_ok & (st == TAP_CAP_DR);
      chain_shift_out <= step & is_intest & sel_ok & (st == TAP_SHIFT_DR);
      chain_update_out <= step & is_intest & sel_ok & (st == TAP_UPD_DR);
      chain_tdi_out <= tdi_s;
      chain_sel_out <= sel_q[1:0];
    end
  end

  // Halted processor takes a store-multiple; chain then drains it
  always_ff @(posedge sys_clk_in) begin
    if (srst_in) begin
      store_multiple_insert_out <= 1'b0;
    end else begin
      store_multiple_insert_out <= step & (st == TAP_UPD_IR) & ice_open &
          cpu_halted_in & (ir_sh_q == `IR_STM_INSERT);
    end
  end

  // ==========================================================
  // Communication channel with the monitor program
  logic [`DCC_W:0] dcc_sh_q;
  logic [`DCC_W-1:0] tx_word_q;
  logic tx_flag_q;
  logic rx_flag_q;
  logic host_take;
  logic host_give;

  assign host_take = step & is_dcc & (st == TAP_CAP_DR) & tx_flag_q;
  assign host_give = step & is_dcc & (st == TAP_UPD_DR) & dcc_sh_q[`DCC_W];

  always_ff @(posedge sys_clk_in) begin
    if (srst_in) begin
      dcc_sh_q <= '0;
    end else if (step && is_dcc) begin
      if (st == TAP_CAP_DR) begin
        dcc_sh_q <= {tx_flag_q, tx_word_q};
      end else if (st == TAP_SHIFT_DR) begin
        dcc_sh_q <= {tdi_s, dcc_sh_q[`DCC_W:1]};
      end
    end
  end

  // Monitor to debugger; a new write wins over the take
  always_ff @(posedge sys_clk_in) begin
    if (srst_in) begin
      tx_word_q <= '0;
      tx_flag_q <= 1'b0;
    end else if (cpu_dcc_wr_in) begin
      tx_word_q <= cpu_dcc_wdata_in;
      tx_flag_q <= 1'b1;
    end else if (host_take) begin
      tx_flag_q <= 1'b0;
    end
  end

  // Debugger to monitor; a new word wins over the read
  always_ff @(posedge sys_clk_in) begin
    if (srst_in) begin
      cpu_dcc_rdata_out <= '0;
      rx_flag_q <= 1'b0;
    end else if (host_give) begin
      cpu_dcc_rdata_out <= dcc_sh_q[`DCC_W-1:0];
      rx_flag_q <= 1'b1;
    end else if (cpu_dcc_rd_in) begin
      rx_flag_q <= 1'b0;
    end
  end

  always_ff @(posedge sys_clk_in) begin
    if (srst_in) begin
      dcc_irq_out <= 1'b0;
    end else begin
      dcc_irq_out <= (rx_flag_q & dcc_rx_irq_en_in) |
          (~tx_flag_q & dcc_tx_irq_en_in);
    end
  end

  assign comm_channel_tx_flag_out = tx_flag_q;
  assign comm_channel_rx_flag_out = rx_flag_q;

  // ==========================================================
  // Test data out, changed on the falling test clock edge
  logic tdo_d;

  always_comb begin
    tdo_d = bypass_q;
    if (st == TAP_SHIFT_IR) begin
      tdo_d = ir_sh_q[0];
    end else if (is_idcode) begin
      tdo_d = id_sh_q[0];
    end else if (is_extest || is_sample) begin
      tdo_d = bsr_sh_q[0];
    end else if (is_scan_n) begin
      tdo_d = sel_sh_q[0];
    end else if (is_intest) begin
      tdo_d = sel_ok ? chain_tdo_in[sel_q[1:0]] : bypass_q;
    end else if (is_dcc) begin
      tdo_d = dcc_sh_q[0];
    end
  end

  always_ff @(posedge sys_clk_in) begin
    if (srst_in) begin
      tdo_out <= 1'b0;
      tdo_oe_out <= 1'b0;
    end else if (tck_fall) begin
      tdo_out <= tdo_d;
      tdo_oe_out <= (st == TAP_SHIFT_DR) || (st == TAP_SHIFT_IR);
    end
  end

  // ==========================================================
  // Debug unit pins and identity
  always_ff @(posedge sys_clk_in) begin
    if (srst_in) begin
      chip_id_out <= CHIP_ID;
      debug_serial_tx_out <= 1'b1;
      uart_rxd_out <= 1'b1;
      pdc_rx_req_out <= 1'b0;
      pdc_tx_req_out <= 1'b0;
    end else begin
      chip_id_out <= CHIP_ID;
      debug_serial_tx_out <= uart_txd_in;
      uart_rxd_out <= rx_s;
      pdc_rx_req_out <= uart_rx_ready_in;
      pdc_tx_req_out <= uart_tx_empty_in;
    end
  end
endmodule // debug_scan_port

// *** verification/debug_scan_port_properties.sv ***
// Port-level assertions of the debug and boundary-scan port
module debug_scan_port_properties #(
  parameter logic [31:0] CHIP_ID = 32'h0
) (
  input wire logic sys_clk_in, // Clock
  input wire logic srst_in, // Reset
  input wire logic tdo_oe_out, // Data out enable
  input wire logic chain_shift_out, // Chain shift
  input wire logic store_multiple_insert_out, // Insert
  input wire logic ice_block_in, // Block access
  input wire logic cpu_dcc_wr_in, // Monitor write
  input wire logic comm_channel_tx_flag_out, // To debugger
  input wire logic comm_channel_rx_flag_out, // To monitor
  input wire logic dcc_tx_irq_en_in, // Enable
  input wire logic dcc_rx_irq_en_in, // Enable
  input wire logic dcc_irq_out, // Source
  input wire logic [31:0] chip_id_out, // Identity
  input wire logic debug_serial_rx_in, // Pin
  input wire logic uart_rxd_out, // Serial unit
  input wire logic uart_txd_in, // Serial unit
  input wire logic debug_serial_tx_out, // Pin
  input wire logic uart_rx_ready_in, // Byte held
  input wire logic pdc_rx_req_out // Request
);
  // ==========================================================
  // Assertions
  default clocking @(posedge sys_clk_in);
  endclocking
  default disable iff (srst_in);
  sequence insert_quiet;
    !store_multiple_insert_out [*8];
  endsequence
  a_reset_quiet: assert property (
    disable iff (1'b0) srst_in |=> !tdo_oe_out && !dcc_irq_out)
    else $error("Port active after reset");
  a_chip_id_fixed: assert property (chip_id_out == CHIP_ID)
    else $error("Chip identity changed");
  a_irq_source: assert property (!$past(srst_in) |-> dcc_irq_out ==
    $past(comm_channel_rx_flag_out && dcc_rx_irq_en_in ||
    !comm_channel_tx_flag_out && dcc_tx_irq_en_in))
    else $error("Channel source wrong");
  a_serial_tx: assert property (
    !$past(srst_in) |-> debug_serial_tx_out == $past(uart_txd_in))
    else $error("Serial transmit not passed");
  a_pdc_request: assert property (
    !$past(srst_in) |-> pdc_rx_req_out == $past(uart_rx_ready_in))
    else $error("Receive request wrong");
  a_rxd_delay: assert property (
    !$past(srst_in) && !$past(srst_in, 2) && !$past(srst_in, 3)
    |-> uart_rxd_out == $past(debug_serial_rx_in, 3))
    else $error("Serial receive latency wrong");
  a_shift_pulse: assert property (chain_shift_out |=> !chain_shift_out)
    else $error("Chain shift longer than a cycle");
  a_block_chains: assert property (
    chain_shift_out |-> !$past(ice_block_in))
    else $error("Chain shifted while blocked");
  a_insert_single: assert property (store_multiple_insert_out |=> insert_quiet)
    else $error("Repeated insert pulse");
  a_tx_flag_set: assert property (cpu_dcc_wr_in |=> comm_channel_tx_flag_out)
    else $error("Monitor word not flagged");
endmodule // debug_scan_port_properties

// *** verification/jtag_tester_model.sv ***
// Scan port tester: test clock, mode select and data pins
module jtag_tester_model (
  input wire logic sys_clk_in, // Bench clock
  input wire logic tdo_in, // Data from device
  output logic tck_out, // Test clock
  output logic tms_out, // Mode select
  output logic tdi_out // Data to device
);
  timeunit 1ns;
  timeprecision 100ps;
  // Factory test select is tied low on this board
  initial begin
    tck_out = 1'b0;
    tms_out = 1'b1;
    tdi_out = 1'b0;
  end
  // ==========================================================
  // Low 5, high 3 clocks; tdo settles before the rise
  task automatic step(input logic ms, input logic di, output logic dout);
    tms_out <= ms;
    tdi_out <= di;
    repeat (5) @(posedge sys_clk_in);
    dout = tdo_in;
    tck_out <= 1'b1;
    repeat (3) @(posedge sys_clk_in);
    tck_out <= 1'b0;
  endtask
  // Data toggles outside shifts so stale bits never pass
  task automatic move(input logic ms);
    logic d;
    step(ms, ~tdi_out, d);
  endtask
  // Idle to Idle through one shift of n bits, LSB first
  task automatic scan(input logic ir, input int n, input logic [96:0] din,
                      output logic [96:0] dout);
    dout = '0;
    move(1'b1);
    if (ir) move(1'b1);
    move(1'b0);
    move(1'b0);
    for (int i = 0; i < n; i++) step(i == n - 1, din[i], dout[i]);
    move(1'b1);
    move(1'b0);
    // Update lands 3 clocks after the rise
    repeat (2) @(posedge sys_clk_in);
  endtask
endmodule // jtag_tester_model

// *** verification/debug_scan_port_tb_top.sv ***
// Self-checking bench of the debug and boundary-scan port
`include "debug_scan_defs.svh"
module debug_scan_port_tb_top;
  timeunit 1ns;
  timeprecision 100ps;
  localparam logic [15:0] T_PART = 16'h3C5A; // Arbitrary value
  localparam logic [10:0] T_MAKER = 11'h155; // Arbitrary value
  localparam logic [31:0] T_PROC = 32'h6B2D4E10; // Arbitrary value
  localparam logic [31:0] T_CHIP = 32'h4A3B2C10; // Arbitrary value
  logic sys_clk_in = 1'b0;
  logic srst_in = 1'b1;
  logic scan_port_select_in = 1'b0;
  logic tck_in, tms_in, tdi_in, tdo_out, tdo_oe_out, tdo_w, erase_in, cpu_halted_in;
  logic [31:0] pad_in, pad_out, pad_oe_out, board_pad, core_out_in, core_oe_in;
  logic [31:0] cpu_dcc_wdata_in, cpu_dcc_rdata_out, chip_id_out;
  logic [1:0] chain_sel_out;
  logic [2:0] chain_tdo_in;
  logic ice_block_in, chain_capture_out, chain_shift_out, chain_update_out, chain_tdi_out;
  logic store_multiple_insert_out, cpu_dcc_wr_in, cpu_dcc_rd_in, dcc_irq_out;
  logic comm_channel_tx_flag_out, comm_channel_rx_flag_out, debug_serial_tx_out;
  logic dcc_tx_irq_en_in, dcc_rx_irq_en_in, debug_serial_rx_in, uart_txd_in;
  logic uart_rxd_out, uart_rx_ready_in, uart_tx_empty_in, pdc_rx_req_out, pdc_tx_req_out;
  int errors = 0;
  int comparisons = 0;
  integer seed = 32'h8FC00A46;
  int shifts, inserts;
  logic [96:0] got, res_v;
  logic [96:0] exp_q[$];
  event res_ev;
  // Pin of each cell group, group 0 nearest tdo
  int pin_of[32] = '{31, 30, 29, 0, 1, 2, 3, 28, 27, 26, 25, 4, 5, 6, 7, 8, 9, 10, 11, 12,
    24, 23, 22, 13, 14, 15, 16, 20, 19, 21, 18, 17};

  always #10 sys_clk_in = ~sys_clk_in;
  // Pads driven by the device win over the board
  assign pad_in = (pad_oe_out & pad_out) | (~pad_oe_out & board_pad);
  assign tdo_w = tdo_oe_out ? tdo_out : 1'bz;

  debug_scan_port #(.ID_PART(T_PART), .ID_MAKER(T_MAKER), .PROC_ID(T_PROC),
    .CHIP_ID(T_CHIP)) i_dut (
    .sys_clk_in, .srst_in, .scan_port_select_in, .tck_in, .tms_in, .tdi_in, .tdo_out,
    .tdo_oe_out, .erase_in, .pad_in, .pad_out, .pad_oe_out, .core_out_in, .core_oe_in,
    .cpu_halted_in, .ice_block_in, .chain_sel_out, .chain_capture_out, .chain_shift_out,
    .chain_update_out, .chain_tdi_out, .chain_tdo_in, .store_multiple_insert_out,
    .cpu_dcc_wr_in, .cpu_dcc_wdata_in, .cpu_dcc_rd_in, .cpu_dcc_rdata_out,
    .comm_channel_tx_flag_out, .comm_channel_rx_flag_out, .dcc_tx_irq_en_in,
    .dcc_rx_irq_en_in, .dcc_irq_out, .chip_id_out, .debug_serial_rx_in,
    .debug_serial_tx_out, .uart_txd_in, .uart_rxd_out, .uart_rx_ready_in,
    .uart_tx_empty_in, .pdc_rx_req_out, .pdc_tx_req_out);
  jtag_tester_model i_tester (.sys_clk_in, .tdo_in(tdo_w), .tck_out(tck_in),
    .tms_out(tms_in), .tdi_out(tdi_in));

  // ==========================================================
  // Background traffic and pulse counters
  always @(posedge sys_clk_in) begin
    {debug_serial_rx_in, uart_txd_in, uart_rx_ready_in, uart_tx_empty_in,
      dcc_tx_irq_en_in, dcc_rx_irq_en_in} <= 6'($random(seed));
    if (chain_shift_out) shifts++;
    if (store_multiple_insert_out) inserts++;
  end
  task automatic chk(input logic [96:0] e, input logic [96:0] g);
    exp_q.push_back(e);
    res_v = g;
    -> res_ev;
    @(posedge sys_clk_in);
  endtask
  initial forever begin
    @(res_ev);
    comparisons++;
    if (res_v !== exp_q[0]) begin
      errors++;
      $display("MISMATCH at %0t: expected %h, got %h", $time, exp_q[0], res_v);
    end
    exp_q.delete(0);
  end
  task automatic ir(input logic [3:0] code);
    i_tester.scan(1'b1, 4, 97'(code), got);
  endtask
  task automatic dr(input int n, input logic [96:0] v);
    i_tester.scan(1'b0, n, v, got);
  endtask
  // Mode select held through the whole reset so the sync pipe settles
  task automatic chip_reset(input logic s);
    logic d;
    scan_port_select_in <= s;
    srst_in <= 1'b1;
    repeat (4) @(posedge sys_clk_in);
    srst_in <= 1'b0;
    repeat (3) @(posedge sys_clk_in);
    i_tester.step(1'b0, 1'b0, d);
  endtask
  task automatic stop_test();
    if (errors == 0 && comparisons > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask

  // ==========================================================
  // Main sequence
  initial begin
    logic [96:0] p, e;
    logic [31:0] w;
    {erase_in, board_pad, core_out_in, core_oe_in, cpu_halted_in, ice_block_in, chain_tdo_in,
      cpu_dcc_wr_in, cpu_dcc_wdata_in, cpu_dcc_rd_in} = '0;
    chip_reset(1'b0);
    dr(32, '0);
    chk(97'(T_PROC), got);
    for (int s = 0; s < 3; s++) begin
      chain_tdo_in <= 3'($random(seed));
      ir(`IR_SCAN_N);
      chk(97'(`IR_CAPTURE), got);
      dr(4, 97'(s));
      ir(`IR_INTEST);
      shifts = 0;
      dr(8, 97'($random(seed)));
      chk(97'({8{chain_tdo_in[s]}}), got);
      chk(97'({2'(s), 8'd8}), 97'({chain_sel_out, 8'(shifts)}));
    end
    cpu_halted_in <= 1'b1;
    for (int b = 0; b < 2; b++) begin
      ice_block_in <= b[0];
      inserts = 0;
      ir(`IR_STM_INSERT);
      chk(97'(b == 0), 97'(inserts));
    end
    ice_block_in <= 1'b0;
    w = $random(seed);
    cpu_dcc_wdata_in <= w;
    cpu_dcc_wr_in <= 1'b1;
    @(posedge sys_clk_in);
    cpu_dcc_wr_in <= 1'b0;
    ir(`IR_DCC);
    p = 97'({1'b1, 32'($random(seed))});
    dr(33, p);
    chk(97'({1'b1, w}), got);
    chk(97'({2'b01, p[31:0]}), 97'({comm_channel_tx_flag_out, comm_channel_rx_flag_out,
      cpu_dcc_rdata_out}));
    // Live change of the select pin must not switch modes
    scan_port_select_in <= 1'b1;
    ir(`IR_IDCODE);
    dr(32, '0);
    chk(97'(T_PROC), got);
    chip_reset(1'b1);
    dr(32, '0);
    chk(97'({4'h0, T_PART, T_MAKER, 1'b1}), got);
    ir(`IR_BYPASS);
    dr(8, 97'(8'hA5));
    chk(97'(8'h4A), got);
    board_pad <= $random(seed);
    core_out_in <= $random(seed);
    core_oe_in <= $random(seed);
    erase_in <= 1'b1;
    @(posedge sys_clk_in);
    e = 97'(erase_in);
    for (int g = 0; g < 32; g++) begin
      e[3*g+1] = core_oe_in[pin_of[g]];
      e[3*g+2] = core_out_in[pin_of[g]];
      e[3*g+3] = core_oe_in[pin_of[g]] ? core_out_in[pin_of[g]] : board_pad[pin_of[g]];
    end
    p = {32'($random(seed)), 32'($random(seed)), 32'($random(seed)), 1'b0};
    ir(`IR_SAMPLE);
    dr(97, p);
    chk(e, got);
    ir(`IR_EXTEST);
    e = '0;
    for (int g = 0; g < 32; g++) begin
      e[pin_of[g]] = p[3*g+2];
      e[32+pin_of[g]] = p[3*g+1];
    end
    chk(e, 97'({pad_oe_out, pad_out}));
    stop_test();
  end
  initial begin
    #400000;
    errors++;
    stop_test();
  end
endmodule // debug_scan_port_tb_top

bind debug_scan_port debug_scan_port_properties #(.CHIP_ID(CHIP_ID)) i_props (
  .sys_clk_in, .srst_in, .tdo_oe_out, .chain_shift_out, .store_multiple_insert_out,
  .ice_block_in, .cpu_dcc_wr_in, .comm_channel_tx_flag_out, .comm_channel_rx_flag_out,
  .dcc_tx_irq_en_in, .dcc_rx_irq_en_in, .dcc_irq_out, .chip_id_out, .debug_serial_rx_in,
  .uart_rxd_out, .uart_txd_in, .debug_serial_tx_out, .uart_rx_ready_in, .pdc_rx_req_out);
